// >>> core/slc_host.sv
`timescale 1ns/100ps
module slc_host
  import slc_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 4
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              req,
  input  wire logic              req_write,
  input  wire logic              req_select_first,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   ready,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  output logic                   select_n,
  output logic                   store_n,
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe
);

  slc_state_t        state_ff,    nxt_state;
  logic              select_n_ff, nxt_select_n;
  logic              store_n_ff,  nxt_store_n;
  logic              dq_oe_ff,    nxt_dq_oe;
  logic              ready_ff,    nxt_ready;
  logic              done_ff,     nxt_done;
  logic              wr_ff,       nxt_wr;
  logic              sf_ff,       nxt_sf;
  logic [ADDR_W-1:0] addr_ff,     nxt_addr;
  logic [DATA_W-1:0] wdata_ff,    nxt_wdata;
  logic [DATA_W-1:0] rdata_ff,    nxt_rdata;
  logic              tmr_load;
  logic [TMR_W-1:0]  tmr_val;
  logic [TMR_W-1:0]  tmr_cnt;
  logic              tmr_exp;

  slc_timer #(
    .W        (TMR_W)
  ) u_timer (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .cnt      (tmr_cnt),
    .expired  (tmr_exp)
  );

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_select_n = select_n_ff;
    nxt_store_n  = store_n_ff;
    nxt_dq_oe    = dq_oe_ff;
    nxt_done     = 1'b0;
    nxt_wr       = wr_ff;
    nxt_sf       = sf_ff;
    nxt_addr     = addr_ff;
    nxt_wdata    = wdata_ff;
    nxt_rdata    = rdata_ff;
    tmr_load     = 1'b0;
    tmr_val      = '0;
    unique case (state_ff)
      ST_IDLE:
      begin
        nxt_select_n = 1'b1;
        if (req)
        begin
          nxt_wr    = req_write;
          nxt_sf    = req_select_first;
          nxt_addr  = req_addr;
          nxt_wdata = req_wdata;
          // strobe-first write drops the strobe before select; reads keep it high
          nxt_store_n = !(req_write && !req_select_first);
          tmr_load  = 1'b1;
          tmr_val   = TMR_W'(CYC_ADDR_SETUP);
          nxt_state = ST_SETUP;
        end
        else
          nxt_store_n = 1'b1;
      end
      ST_SETUP:
        if (tmr_exp)
        begin
          nxt_select_n = 1'b0;
          // strobe already low, RAM is floating, so data may go out now
          nxt_dq_oe = wr_ff && !sf_ff;
          tmr_load  = 1'b1;
          tmr_val   = (wr_ff && sf_ff) ? TMR_W'(CYC_ADDR_HOLD) : TMR_W'(CYC_SELECT_LOW);
          nxt_state = ST_SEL;
        end
      ST_SEL:
        if (tmr_exp)
        begin
          tmr_load = 1'b1;
          if (wr_ff && sf_ff)
          begin
            // strobe goes low only once the address hold after select has run out
            nxt_store_n = 1'b0;
            tmr_val     = TMR_W'(CYC_STORE_PULSE);
            nxt_state   = ST_WLOW;
          end
          else
          begin
            if (!wr_ff)
            begin
              nxt_rdata = dq_in;
              nxt_done  = 1'b1;
            end
            else
              nxt_done = 1'b1;
            nxt_select_n = 1'b1;
            tmr_val      = TMR_W'(CYC_SELECT_HIGH);
            nxt_state    = ST_RECOV;
          end
        end
      ST_WLOW:
      begin
        // RAM needs the drive delay to float its outputs first
        if (tmr_cnt <= TMR_W'(CNT_DRIVE_START))
          nxt_dq_oe = 1'b1;
        if (tmr_exp)
        begin
          // both strobes rise together so the RAM never re-drives the bus
          nxt_select_n = 1'b1;
          nxt_store_n  = 1'b1;
          nxt_done     = 1'b1;
          tmr_load     = 1'b1;
          tmr_val      = TMR_W'(CYC_SELECT_HIGH);
          nxt_state    = ST_RECOV;
        end
      end
      ST_RECOV:
      begin
        nxt_dq_oe = 1'b0;
        if (tmr_exp)
          nxt_state = ST_IDLE; // strobe of a strobe-first write stays low for a possible follow-on write
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    nxt_ready = (nxt_state == ST_IDLE);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_ff    <= ST_IDLE;
      select_n_ff <= 1'b1;
      store_n_ff  <= 1'b1;
      dq_oe_ff    <= 1'b0;
      ready_ff    <= 1'b0;
      done_ff     <= 1'b0;
      wr_ff       <= 1'b0;
      sf_ff       <= 1'b0;
      addr_ff     <= '0;
      wdata_ff    <= '0;
      rdata_ff    <= '0;
    end
    else
    begin
      state_ff    <= nxt_state;
      select_n_ff <= nxt_select_n;
      store_n_ff  <= nxt_store_n;
      dq_oe_ff    <= nxt_dq_oe;
      ready_ff    <= nxt_ready;
      done_ff     <= nxt_done;
      wr_ff       <= nxt_wr;
      sf_ff       <= nxt_sf;
      addr_ff     <= nxt_addr;
      wdata_ff    <= nxt_wdata;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign ready    = ready_ff;
  assign done     = done_ff;
  assign rdata    = rdata_ff;
  assign select_n = select_n_ff;
  assign store_n  = store_n_ff;
  assign mem_addr = addr_ff;
  assign dq_out   = wdata_ff;
  assign dq_oe    = dq_oe_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence store_fall_s;
    $fell(store_n_ff);
  endsequence

  sequence drive_after_delay_s;
    store_fall_s ##3 $rose(dq_oe_ff);
  endsequence

  addr_hold_a: assert property ($fell(select_n_ff) |-> $stable(addr_ff) [*2])
    else $error("address moved around select fall");
  read_store_a: assert property ((!select_n_ff && !wr_ff) |-> store_n_ff)
    else $error("store strobe low during read");
  drive_delay_a: assert property (($rose(dq_oe_ff) && sf_ff) |->
      (!store_n_ff && $past(store_n_ff, 3) == 1'b0 && $past(store_n_ff, 4)))
    else $error("data driven before drive delay");
  sel_first_a: assert property (($fell(select_n_ff) && wr_ff && sf_ff) |->
      store_n_ff ##[1:3] store_fall_s ##3 $rose(dq_oe_ff))
    else $error("select-first write order wrong");
  store_first_a: assert property (($fell(select_n_ff) && wr_ff && !sf_ff) |->
      (!store_n_ff && $past(!store_n_ff) && $rose(dq_oe_ff)))
    else $error("strobe not low before select fall");
  setup_select_a: assert property (($rose(select_n_ff) && wr_ff && !sf_ff) |->
      (dq_oe_ff && $past(dq_oe_ff, 5) && !store_n_ff) ##1 !dq_oe_ff)
    else $error("data setup or hold to select rise broken");
  chain_store_a: assert property (($rose(select_n_ff) && wr_ff && !sf_ff) |->
      !store_n_ff [*4])
    else $error("strobe rose early in strobe-first write");
  idle_deselect_a: assert property ((state_ff == ST_IDLE || $past(srst)) |-> select_n_ff)
    else $error("select low while idle");
  select_width_a: assert property ($fell(select_n_ff) |-> !select_n_ff [*8])
    else $error("select low too short");
  select_high_a: assert property ($rose(select_n_ff) |-> select_n_ff [*3])
    else $error("select high too short");
  oe_store_a: assert property ($rose(dq_oe_ff) |-> !store_n_ff)
    else $error("bus driven with store strobe high");

endmodule : slc_host

// >>> core/slc_pkg.sv
package slc_pkg;

  localparam int CLK_PERIOD_NS = 40;

  function automatic int slc_cyc_min(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : slc_cyc_min

  // bus timing, in ns as printed
  localparam int T_ADDR_SETUP_NS                  = 20;
  localparam int T_ADDR_HOLD_NS                   = 50;
  localparam int T_SELECT_LOW_NS                  = 300;
  localparam int T_SELECT_HIGH_NS                 = 120;
  localparam int T_STORE_PULSE_NS                 = 300;
  localparam int T_STORE_TO_BUS_DRIVE_DELAY_NS    = 100;
  localparam int T_WRITE_DATA_SETUP_NS            = 200;
  localparam int T_DESELECT_OUTPUT_FLOAT_NS       = 100;

  localparam int CYC_ADDR_SETUP   = slc_cyc_min(T_ADDR_SETUP_NS);
  localparam int CYC_ADDR_HOLD    = slc_cyc_min(T_ADDR_HOLD_NS);
  localparam int CYC_SELECT_LOW   = slc_cyc_min(T_SELECT_LOW_NS);
  localparam int CYC_SELECT_HIGH  = slc_cyc_min(T_SELECT_HIGH_NS);
  localparam int CYC_STORE_PULSE  = slc_cyc_min(T_STORE_PULSE_NS);
  localparam int CYC_DRIVE_DELAY  = slc_cyc_min(T_STORE_TO_BUS_DRIVE_DELAY_NS);
  localparam int CYC_DATA_SETUP   = slc_cyc_min(T_WRITE_DATA_SETUP_NS);
  localparam int CYC_FLOAT        = slc_cyc_min(T_DESELECT_OUTPUT_FLOAT_NS);

  // store pulse count at which write data is launched
  localparam int CNT_DRIVE_START  = CYC_STORE_PULSE - CYC_DRIVE_DELAY + 1;

  localparam int TMR_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_SEL   = 3'h2,
    ST_WLOW  = 3'h3,
    ST_RECOV = 3'h4
  } slc_state_t;

endpackage : slc_pkg

// >>> core/slc_timer.sv
`timescale 1ns/100ps
module slc_timer
  import slc_pkg::*;
#(
  parameter int W = TMR_W
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic [W-1:0]      cnt,
  output logic              expired
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (load)
      nxt_cnt = load_val;
    else if (cnt_ff != '0)
      nxt_cnt = cnt_ff - W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign cnt     = cnt_ff;
  assign expired = (cnt_ff == '0);

endmodule : slc_timer

// >>> dv/latched_addr_sram_cycle_tb.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module latched_addr_sram_cycle_tb
  import slc_pkg::*;
;
  typedef struct {logic w; logic sf; logic [9:0] a; logic [3:0] d;} slc_row_t;

  logic        core_clk         = 1'b0;
  logic        srst             = 1'b1;
  logic        req              = 1'b0;
  logic        req_write        = 1'b0;
  logic        req_select_first = 1'b0;
  logic [9:0]  req_addr         = 10'h000;
  logic [3:0]  req_wdata        = 4'h0;
  logic [3:0]  float_v          = 4'h5;
  logic        ready, done, select_n, store_n, dq_oe, ram_oe;
  logic [3:0]  rdata, dq_out, dq_in, ram_q;
  logic [9:0]  mem_addr;
  int          num_errors       = 0;
  int          tests_run        = 0;
  int          cycles           = 0;
  slc_row_t    rows [8] = '{
    '{1'b1, 1'b0, 10'h000, 4'h5}, '{1'b1, 1'b0, 10'h3ff, 4'ha},
    '{1'b1, 1'b1, 10'h155, 4'hc}, '{1'b1, 1'b1, 10'h2aa, 4'h3},
    '{1'b0, 1'b0, 10'h000, 4'h5}, '{1'b0, 1'b0, 10'h3ff, 4'ha},
    '{1'b0, 1'b0, 10'h155, 4'hc}, '{1'b0, 1'b0, 10'h2aa, 4'h3}};

  slc_host i_dut (.core_clk(core_clk), .srst(srst), .req(req), .req_write(req_write),
    .req_select_first(req_select_first), .req_addr(req_addr), .req_wdata(req_wdata),
    .ready(ready), .done(done), .rdata(rdata), .select_n(select_n), .store_n(store_n),
    .mem_addr(mem_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  slc_ram_model #(.ADDR_W(10), .DATA_W(4)) i_ram (.core_clk(core_clk), .select_n(select_n),
    .store_n(store_n), .addr(mem_addr), .bus(dq_in), .ram_q(ram_q), .ram_oe(ram_oe));

  initial forever #20 core_clk = ~core_clk;

  // a released bus toggles so a stale value never reads as valid
  assign dq_in = dq_oe ? dq_out : (ram_oe ? ram_q : float_v);
  always @(posedge core_clk) float_v <= ~float_v;

  task complete_run;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  always @(negedge core_clk)
  begin
    cycles++;
    if (!srst)
    begin
      `CHK("bus_clash", 1'b0, dq_oe & ram_oe)
      if (ready === 1'b1) `CHK("idle_select", 1'b1, select_n)
    end
    if (cycles == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end

  task do_req(input logic w, input logic sf, input logic [9:0] a, input logic [3:0] d);
    int n;
    int lowc;
    n = 0;
    lowc = 0;
    while (ready !== 1'b1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    req = 1'b1;
    req_write = w;
    req_select_first = sf;
    req_addr = a;
    req_wdata = d;
    @(negedge core_clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100)
    begin
      if (select_n === 1'b0)
      begin
        `CHK("addr_hold", a, mem_addr)
        if (!w) `CHK("store_rd", 1'b1, store_n)
        if (w && !sf) `CHK("store_first", 1'b0, store_n)
        if (w && sf && store_n === 1'b1) `CHK("early_drive", 1'b0, dq_oe)
        lowc++;
      end
      @(negedge core_clk);
      n++;
    end
    `CHK("done", 1'b1, done)
    `CHK("select_len", 1'b1, lowc >= CYC_SELECT_LOW)
    if (!w) `CHK("rdata", d, rdata)
  endtask : do_req

  initial
  begin
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    `CHK("rst_select", 1'b1, select_n)
    `CHK("rst_store", 1'b1, store_n)
    foreach (rows[i]) do_req(rows[i].w, rows[i].sf, rows[i].a, rows[i].d);
    // request while busy is dropped, so 0x0bb keeps its reset content
    `CHK("busy", 1'b0, ready)
    req = 1'b1;
    req_write = 1'b1;
    req_addr = 10'h0bb;
    req_wdata = 4'h7;
    @(negedge core_clk);
    req = 1'b0;
    do_req(1'b0, 1'b0, 10'h0bb, 4'h0);
    // reset in mid write; the aborted location is not read back
    while (ready !== 1'b1) @(negedge core_clk);
    req = 1'b1;
    req_write = 1'b1;
    req_select_first = 1'b1;
    req_addr = 10'h155;
    req_wdata = 4'h9;
    @(negedge core_clk);
    req = 1'b0;
    repeat (6) @(negedge core_clk);
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("mid_rst_select", 1'b1, select_n)
    `CHK("mid_rst_oe", 1'b0, dq_oe)
    `CHK("mid_rst_store", 1'b1, store_n)
    srst = 1'b0;
    do_req(1'b0, 1'b0, 10'h3ff, 4'ha);
    complete_run();
  end
endmodule : latched_addr_sram_cycle_tb

// >>> dv/slc_ram_model.sv
`timescale 1ns/100ps
module slc_ram_model
#(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 4
) (
  input  wire logic              core_clk,
  input  wire logic              select_n,
  input  wire logic              store_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] bus,
  output logic [DATA_W-1:0]      ram_q,
  output logic                   ram_oe
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0] lat   = '0;
  logic [DATA_W-1:0] wd    = '0;
  logic [1:0]        cnt   = 2'h0;
  logic              sel_q = 1'b1;
  logic              st_q  = 1'b1;

  initial
  begin
    foreach (mem[i]) mem[i] = '0;
  end

  always @(negedge select_n) lat <= addr;

  // drives whenever selected with store high, as a real part may
  assign ram_oe = !select_n && store_n;
  // early phase shows junk so a too-early sample cannot pass
  assign ram_q = (cnt < 2'h2) ? ~mem[lat] : mem[lat];

  always @(posedge core_clk)
  begin
    sel_q <= select_n;
    st_q  <= store_n;
    cnt   <= select_n ? 2'h0 : ((cnt == 2'h3) ? cnt : cnt + 2'h1);
    if (!select_n && !store_n)
      wd <= bus;
    // data is taken as the select rises if store was low the cycle before
    if (!sel_q && select_n && !st_q)
      mem[lat] <= wd;
  end
endmodule : slc_ram_model
